// file: design/rcr_top.sv
// Configuration register slice of a quad buck controller: voltage codes, scaling and mode/discharge.
// Assumes a serial front end delivering one-cycle byte accesses, and fuse values stable during reset.
//
// Behaviour
// (R1) Channel 3 code bits 6:4: 000 adjustable 0.8 V, else 1.2 to 1.8 V.
// (R2) Channel 2 code bits 2:0: 000 adjustable, else 3.3 to 5.0 V table.
// (R3) Channel 4 code bits 4:0: 00000 adjustable, 00001 2.5 V up to 5.5 V.
// (R4) Voltage codes load from fuse values at power-on reset.
// (R5) Channel 4 scaling enable, bit 6, resets to 0; 1 enables.
// (R6) Channel 4 interval bits 5:4 select 62.5, 31.2, 15.6, 7.8 us.
// (R7) Channel 1 scaling enable, bit 2, resets to 0; 1 enables.
// (R8) Channel 1 interval bits 1:0 use same encoding, reset 00.
// (R9) Scaling register: bits 7 and 3 reserved, channel 4 in upper nibble.
// (R10) Mode pin low forces all channels to auto power-save, ignoring mode bits.
// (R11) Mode bits act only with pin high or pin configured as clock.
// (R12) Address 0x06 holds mode and discharge enable for all four channels.
// (R13) Discharge defaults come from one common fuse for all channels.
// (R14) Mode bits reset to 0, forced PWM; 1 selects auto power-save.
// (R15) Discharge bit 1 enables active output discharge, 0 disables.
// (R16) Channel 4 codes step linearly 0.1 V between 2.5 V and 5.5 V.
// (R17) Reserved bits are writable, read back, and steer nothing.
`timescale 1ns/100ps
module rcr_top #(
	parameter int unsigned STEP_CYC_62P5 = rcr_pkg::STEP_62P5_CYC,
	parameter int unsigned STEP_CYC_31P2 = rcr_pkg::STEP_31P2_CYC
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  resetn,
	// Register port
	input  wire rcr_pkg::rcr_req_s     req,
	output logic [7:0]                 rdata,
	output logic                       rvalid,
	// Factory fuses
	input  wire logic [2:0]            fuse_ch2_code,
	input  wire logic [2:0]            fuse_ch3_code,
	input  wire logic [4:0]            fuse_ch4_code,
	input  wire logic                  fuse_discharge_en,
	// Mode/sync pin
	input  wire logic                  mode_pin,
	input  wire logic                  mode_pin_is_clock,
	// Regulator controls
	output logic [12:0]                ch2_target_mv,
	output logic [12:0]                ch3_target_mv,
	output logic [12:0]                ch4_target_mv,
	output logic [3:0]                 chan_adjustable,
	output rcr_pkg::rcr_chan_cfg_s [3:0] chan_cfg,
	output logic                       ch1_scaling_en,
	output logic                       ch4_scaling_en,
	output logic [1:0]                 scaling_step_tick
);

	logic [7:0] ch23_r;
	logic [7:0] ch4_r;
	logic [7:0] scal_r;
	logic [7:0] mode_r;
	logic [2:0] ch2_volt_code;
	logic [2:0] ch3_volt_code;
	logic [4:0] ch4_volt_code;
	logic [3:0] chan_auto_powersave_sel;
	logic [3:0] dscg_sel;
	logic [1:0] ch1_scaling_interval;
	logic [1:0] ch4_scaling_interval;
	logic [1:0] scal_en;
	logic [1:0] scal_intvl [2];
	logic [12:0] ch2_mv_nxt;
	logic [12:0] ch3_mv_nxt;
	logic [12:0] ch4_mv_nxt;

	assign ch2_volt_code           = ch23_r[rcr_pkg::CH2_CODE_LSB +: 3];
	assign ch3_volt_code           = ch23_r[rcr_pkg::CH3_CODE_LSB +: 3];
	assign ch4_volt_code           = ch4_r[rcr_pkg::CH4_CODE_LSB +: 5];
	assign ch1_scaling_interval    = scal_r[rcr_pkg::CH1_INTVL_LSB +: 2];
	assign ch4_scaling_interval    = scal_r[rcr_pkg::CH4_INTVL_LSB +: 2];
	assign chan_auto_powersave_sel = mode_r[rcr_pkg::AUTO_PS_LSB +: 4];
	assign dscg_sel                = mode_r[rcr_pkg::DSCG_LSB +: 4];

	////////////////////////////////////////////////////////////////////////////////////////////
	// Register file.

	// (R4) fuse-loaded voltage codes
	always_ff @(posedge clock) begin
		if (!resetn) begin
			ch23_r <= {1'b0, fuse_ch3_code, 1'b0, fuse_ch2_code};
		end else if (req.wr && req.addr == rcr_pkg::ADDR_CH23_CODES) begin
			// (R17) reserved bits stored
			ch23_r <= req.wdata;
		end
	end

	// (R4) fuse-loaded channel 4 code
	always_ff @(posedge clock) begin
		if (!resetn)
			ch4_r <= {3'h0, fuse_ch4_code};
		else if (req.wr && req.addr == rcr_pkg::ADDR_CH4_CODE)
			ch4_r <= req.wdata;
	end

	// (R5) (R7) (R9) scaling reset values
	always_ff @(posedge clock) begin
		if (!resetn)
			scal_r <= rcr_pkg::SCALING_CFG_RST;
		else if (req.wr && req.addr == rcr_pkg::ADDR_SCALING_CFG)
			scal_r <= req.wdata;
	end

	// (R12) (R13) (R14) shared mode/discharge register
	always_ff @(posedge clock) begin
		if (!resetn)
			mode_r <= {{4{fuse_discharge_en}}, rcr_pkg::AUTO_PS_RST};
		else if (req.wr && req.addr == rcr_pkg::ADDR_MODE_DSCG)
			mode_r <= req.wdata;
	end

	// Read data is registered one cycle after the read strobe; unmapped reads give zero.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			rdata  <= rcr_pkg::RSVD_RST;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			if (req.rd) begin
				case (req.addr)
					rcr_pkg::ADDR_CH23_CODES:  rdata <= ch23_r;
					rcr_pkg::ADDR_CH4_CODE:    rdata <= ch4_r;
					rcr_pkg::ADDR_SCALING_CFG: rdata <= scal_r;
					rcr_pkg::ADDR_MODE_DSCG:   rdata <= mode_r;
					default:                   rdata <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Voltage code decoding.

	always_comb begin
		// (R2) channel 2 table
		case (ch2_volt_code)
			3'h1:    ch2_mv_nxt = rcr_pkg::MV_CH2_3V3;
			3'h2:    ch2_mv_nxt = rcr_pkg::MV_CH2_3V6;
			3'h3:    ch2_mv_nxt = rcr_pkg::MV_CH2_3V9;
			3'h4:    ch2_mv_nxt = rcr_pkg::MV_CH2_4V2;
			3'h5:    ch2_mv_nxt = rcr_pkg::MV_CH2_4V5;
			3'h6:    ch2_mv_nxt = rcr_pkg::MV_CH2_4V8;
			3'h7:    ch2_mv_nxt = rcr_pkg::MV_CH2_5V0;
			default: ch2_mv_nxt = rcr_pkg::MV_ADJUST;
		endcase
		// (R1) channel 3 linear steps
		if (ch3_volt_code == 3'h0)
			ch3_mv_nxt = rcr_pkg::MV_ADJUST;
		else
			ch3_mv_nxt = 13'(rcr_pkg::MV_CH3_BASE + rcr_pkg::MV_STEP * {10'h000, ch3_volt_code});
		// (R3) (R16) channel 4 linear steps
		if (ch4_volt_code == 5'h00)
			ch4_mv_nxt = rcr_pkg::MV_ADJUST;
		else
			ch4_mv_nxt = 13'(rcr_pkg::MV_CH4_BASE + rcr_pkg::MV_STEP * {8'h00, ch4_volt_code - 5'h01});
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			ch2_target_mv   <= rcr_pkg::MV_ADJUST;
			ch3_target_mv   <= rcr_pkg::MV_ADJUST;
			ch4_target_mv   <= rcr_pkg::MV_ADJUST;
			chan_adjustable <= 4'h0;
		end else begin
			ch2_target_mv   <= ch2_mv_nxt;
			ch3_target_mv   <= ch3_mv_nxt;
			ch4_target_mv   <= ch4_mv_nxt;
			chan_adjustable <= {ch4_volt_code == 5'h00, ch3_volt_code == 3'h0, ch2_volt_code == 3'h0, 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Operating mode and discharge.

	always_ff @(posedge clock) begin
		if (!resetn) begin
			chan_cfg <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				// (R10) (R11) pin gating of mode bits
				chan_cfg[i].auto_ps <= (mode_pin || mode_pin_is_clock) ? chan_auto_powersave_sel[i] : 1'b1;
				// (R15) discharge enable
				chan_cfg[i].discharge_en <= dscg_sel[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Dynamic voltage scaling step timing.

	// (R5) (R7) scaling enables
	assign scal_en       = {scal_r[rcr_pkg::CH4_SCALE_BIT], scal_r[rcr_pkg::CH1_SCALE_BIT]};
	assign scal_intvl[0] = ch1_scaling_interval;
	assign scal_intvl[1] = ch4_scaling_interval;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			ch1_scaling_en <= 1'b0;
			ch4_scaling_en <= 1'b0;
		end else begin
			ch1_scaling_en <= scal_en[0];
			ch4_scaling_en <= scal_en[1];
		end
	end

	generate
		for (genvar g = 0; g < 2; g++) begin : gen_step
			// (R6) (R8) interval selection
			rcr_step_timer #(
				.CYC_0 (STEP_CYC_62P5),
				.CYC_1 (STEP_CYC_31P2),
				.CYC_2 (rcr_pkg::STEP_15P6_CYC),
				.CYC_3 (rcr_pkg::STEP_7P8_CYC)
			) u_timer (
				.clock     (clock),
				.resetn    (resetn),
				.enable    (scal_en[g]),
				.interval  (scal_intvl[g]),
				.step_tick (scaling_step_tick[g])
			);
		end
	endgenerate

endmodule

// file: pkg/rcr_pkg.sv
// Constants and carriers for the regulator configuration register slice.
// Assumes a single 250 MHz clock and a byte-wide register port from the serial front end.
package rcr_pkg;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CH23_CODES   = 8'h03;
	localparam logic [7:0] ADDR_CH4_CODE     = 8'h04;
	localparam logic [7:0] ADDR_SCALING_CFG  = 8'h05;
	localparam logic [7:0] ADDR_MODE_DSCG    = 8'h06;

	// Field positions.
	localparam int CH2_CODE_LSB   = 0;
	localparam int CH3_CODE_LSB   = 4;
	localparam int CH4_CODE_LSB   = 0;
	localparam int CH1_INTVL_LSB  = 0;
	localparam int CH1_SCALE_BIT  = 2;
	localparam int CH4_INTVL_LSB  = 4;
	localparam int CH4_SCALE_BIT  = 6;
	localparam int AUTO_PS_LSB    = 0;
	localparam int DSCG_LSB       = 4;

	// Values after reset that are not fuse driven.
	localparam logic [7:0] SCALING_CFG_RST = 8'h00;
	localparam logic [3:0] AUTO_PS_RST     = 4'h0;
	localparam logic [7:0] RSVD_RST        = 8'h00;

	// Voltages in millivolts.
	localparam logic [12:0] MV_ADJUST     = 13'h0320;
	localparam logic [12:0] MV_STEP       = 13'h0064;
	localparam logic [12:0] MV_CH3_BASE   = 13'h044C;
	localparam logic [12:0] MV_CH4_BASE   = 13'h09C4;
	localparam logic [12:0] MV_CH2_3V3    = 13'h0CE4;
	localparam logic [12:0] MV_CH2_3V6    = 13'h0E10;
	localparam logic [12:0] MV_CH2_3V9    = 13'h0F3C;
	localparam logic [12:0] MV_CH2_4V2    = 13'h1068;
	localparam logic [12:0] MV_CH2_4V5    = 13'h1194;
	localparam logic [12:0] MV_CH2_4V8    = 13'h12C0;
	localparam logic [12:0] MV_CH2_5V0    = 13'h1388;

	// Scaling step intervals in ns and the derived cycle counts.
	localparam int CLK_PERIOD_NS  = 4;
	localparam int STEP_62P5_NS   = 62500;
	localparam int STEP_31P2_NS   = 31200;
	localparam int STEP_15P6_NS   = 15600;
	localparam int STEP_7P8_NS    = 7800;
	localparam int STEP_62P5_CYC  = STEP_62P5_NS / CLK_PERIOD_NS;
	localparam int STEP_31P2_CYC  = STEP_31P2_NS / CLK_PERIOD_NS;
	localparam int STEP_15P6_CYC  = STEP_15P6_NS / CLK_PERIOD_NS;
	localparam int STEP_7P8_CYC   = STEP_7P8_NS / CLK_PERIOD_NS;
	localparam int STEP_CNT_W     = 14;

	// One register access from the serial front end.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rcr_req_s;

	// Per-channel effective operating settings.
	typedef struct packed {
		logic auto_ps;
		logic discharge_en;
	} rcr_chan_cfg_s;

endpackage

// file: design/rcr_step_timer.sv
// Step-interval tick generator for one scaling channel.
// Assumes the interval code is stable most of the time; a change restarts the count.
`timescale 1ns/100ps
module rcr_step_timer #(
	parameter int unsigned CYC_0 = 15625,
	parameter int unsigned CYC_1 = 7800,
	parameter int unsigned CYC_2 = 3900,
	parameter int unsigned CYC_3 = 1950
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       resetn,
	// Control
	input  wire logic       enable,
	input  wire logic [1:0] interval,
	// Tick
	output logic            step_tick
);

	logic [rcr_pkg::STEP_CNT_W-1:0] count_r;
	logic [rcr_pkg::STEP_CNT_W-1:0] limit;
	logic [1:0]                     interval_r;

	always_comb begin
		case (interval)
			2'h0:    limit = rcr_pkg::STEP_CNT_W'(CYC_0 - 1);
			2'h1:    limit = rcr_pkg::STEP_CNT_W'(CYC_1 - 1);
			2'h2:    limit = rcr_pkg::STEP_CNT_W'(CYC_2 - 1);
			default: limit = rcr_pkg::STEP_CNT_W'(CYC_3 - 1);
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			interval_r <= 2'h0;
		else
			interval_r <= interval;
	end

	// Count restarts when disabled, when the interval changes, or on the edge that issues a tick.
	always_ff @(posedge clock) begin
		if (!resetn || !enable || interval != interval_r || count_r >= limit)
			count_r <= '0;
		else
			count_r <= count_r + 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			step_tick <= 1'b0;
		else
			step_tick <= enable && interval == interval_r && count_r >= limit;
	end

endmodule

// file: dv/rcr_asserts.sv
// Port checker for the configuration register slice.
// Assumes it is bound onto rcr_top and sees that module's ports only.
`timescale 1ns/100ps
module rcr_asserts #(
	parameter int unsigned STEP_CYC_62P5 = 40,
	parameter int unsigned STEP_CYC_31P2 = 20
) (
	// Clock and reset
	input wire logic			clock,
	input wire logic			resetn,
	// Register port
	input wire rcr_pkg::rcr_req_s		req,
	input wire logic			rvalid,
	// Mode pin
	input wire logic			mode_pin,
	input wire logic			mode_pin_is_clock,
	// Regulator controls
	input wire logic [12:0]			ch3_target_mv,
	input wire rcr_pkg::rcr_chan_cfg_s [3:0]	chan_cfg,
	input wire logic			ch1_scaling_en,
	input wire logic			ch4_scaling_en,
	input wire logic [1:0]			scaling_step_tick
);
	logic [3:0]	auto_v;
	logic [3:0]	dscg_v;
	logic		w03;
	logic		w05;
	logic		w06;

	assign w03 = req.wr && req.addr == rcr_pkg::ADDR_CH23_CODES;
	assign w05 = req.wr && req.addr == rcr_pkg::ADDR_SCALING_CFG;
	assign w06 = req.wr && req.addr == rcr_pkg::ADDR_MODE_DSCG;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			auto_v[i] = chan_cfg[i].auto_ps;
			dscg_v[i] = chan_cfg[i].discharge_en;
		end
	end

	////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	a_read_answer: assert property (req.rd |=> rvalid) else $error("No rvalid after read.");
	a_pin_low_auto: assert property (!mode_pin && !mode_pin_is_clock |=> auto_v == 4'hF)
		else $error("Low pin did not force auto mode.");
	a_mode_bits_apply: assert property (w06 ##1 (!w06 && (mode_pin || mode_pin_is_clock))
		|=> auto_v == $past(req.wdata[3:0], 2)) else $error("Mode bits not applied.");
	a_discharge_apply: assert property (w06 ##1 !w06 |=> dscg_v == $past(req.wdata[7:4], 2))
		else $error("Discharge bits not applied.");
	a_ch1_scale_en: assert property (w05 ##1 !w05 |=> ch1_scaling_en == $past(req.wdata[2], 2))
		else $error("Channel 1 scaling enable wrong.");
	a_ch4_scale_en: assert property (w05 ##1 !w05 |=> ch4_scaling_en == $past(req.wdata[6], 2))
		else $error("Channel 4 scaling enable wrong.");
	a_ch3_decode: assert property (w03 ##1 !w03 |=> ch3_target_mv == (($past(req.wdata[6:4], 2) == 3'h0) ?
		rcr_pkg::MV_ADJUST : rcr_pkg::MV_CH3_BASE + rcr_pkg::MV_STEP * 13'($past(req.wdata[6:4], 2))))
		else $error("Channel 3 voltage wrong.");
	a_tick_gap_min: assert property (scaling_step_tick[0] |=> !scaling_step_tick[0] [*8])
		else $error("Channel 1 ticks too close.");

	c_mode_write: cover property (w06 ##2 mode_pin);
	c_read: cover property (req.rd ##1 rvalid);
	c_tick: cover property (scaling_step_tick[1]);
endmodule

bind rcr_top rcr_asserts #(.STEP_CYC_62P5(STEP_CYC_62P5), .STEP_CYC_31P2(STEP_CYC_31P2)) i_asserts (
	.clock(clock), .resetn(resetn), .req(req), .rvalid(rvalid), .mode_pin(mode_pin),
	.mode_pin_is_clock(mode_pin_is_clock), .ch3_target_mv(ch3_target_mv), .chan_cfg(chan_cfg),
	.ch1_scaling_en(ch1_scaling_en), .ch4_scaling_en(ch4_scaling_en), .scaling_step_tick(scaling_step_tick)
);

// file: dv/rcr_host_model.sv
// Register host model issuing one-cycle byte accesses.
// Assumes requests change at the falling clock edge.
`timescale 1ns/100ps
module rcr_host_model (
	// Clock
	input wire logic		clock,
	// Register port
	output rcr_pkg::rcr_req_s	req,
	input wire logic [7:0]		rdata,
	input wire logic		rvalid
);
	initial req = '0;

	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clock);
		req = '0;
	endtask

	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clock);
		req = '{1'b0, 1'b1, a, 8'h00};
		// rvalid stands for exactly one cycle after the read edge (rdata holds until the next read), so the answer is taken here.
		@(negedge clock);
		d = rdata;
		v = rvalid;
		req = '0;
	endtask
endmodule

// file: dv/tb_regulator_config_registers.sv
// Self-checking bench for the configuration register slice.
// Assumes the package, design, host model and checker are compiled first.
`timescale 1ns/100ps
module tb_regulator_config_registers;
	logic				clock = 1'b0;
	logic				resetn = 1'b0;
	logic				mode_pin = 1'b1;
	logic				pin_clk = 1'b0;
	logic [2:0]			f2 = 3'h5;
	logic [2:0]			f3 = 3'h3;
	logic [4:0]			f4 = 5'h11;
	logic				fd = 1'b1;
	rcr_pkg::rcr_req_s		req;
	logic [7:0]			rdata;
	logic				rvalid, en1, en4;
	logic [12:0]			mv2, mv3, mv4;
	logic [3:0]			adj;
	logic [1:0]			tick;
	rcr_pkg::rcr_chan_cfg_s [3:0]	cfg;
	int				n_errors = 0;
	int				checks_done = 0;
	int				cycles = 0;
	int				c4 [6] = '{0, 1, 2, 6, 16, 31};
	int				m4 [6] = '{800, 2500, 2600, 3000, 4000, 5500};
	logic [12:0]			t2 [8] = '{rcr_pkg::MV_ADJUST, rcr_pkg::MV_CH2_3V3, rcr_pkg::MV_CH2_3V6,
		rcr_pkg::MV_CH2_3V9, rcr_pkg::MV_CH2_4V2, rcr_pkg::MV_CH2_4V5, rcr_pkg::MV_CH2_4V8, rcr_pkg::MV_CH2_5V0};

	always #2 clock = ~clock;

	rcr_top #(.STEP_CYC_62P5(40), .STEP_CYC_31P2(20)) i_dut (
		.clock(clock), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
		.fuse_ch2_code(f2), .fuse_ch3_code(f3), .fuse_ch4_code(f4), .fuse_discharge_en(fd),
		.mode_pin(mode_pin), .mode_pin_is_clock(pin_clk), .ch2_target_mv(mv2), .ch3_target_mv(mv3),
		.ch4_target_mv(mv4), .chan_adjustable(adj), .chan_cfg(cfg), .ch1_scaling_en(en1),
		.ch4_scaling_en(en4), .scaling_step_tick(tick)
	);
	rcr_host_model i_host (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));

	////////////////////////////////////////
	task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0]	d;
		logic		v;
		i_host.read(a, d, v);
		check("rvalid", 13'h0001, {12'h000, v});
		check("rdata", {5'h00, exp}, {5'h00, d});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.write(a, d);
		repeat (2) @(negedge clock);
	endtask

	task automatic tick_gap(input int b, input int exp);
		int n = 0;
		while (tick[b] !== 1'b1 && n < 9000) begin
			@(negedge clock);
			n++;
		end
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (tick[b] !== 1'b1 && n < 9000);
		check("tick gap", 13'(exp), 13'(n));
	endtask

	function automatic logic [12:0] cfg_exp(input logic [3:0] a, input logic [3:0] d);
		cfg_exp = '0;
		for (int i = 0; i < 4; i++) cfg_exp[2*i +: 2] = {a[i], d[i]};
	endfunction

	task automatic complete_run();
		if (n_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_errors++;
			complete_run();
		end
	end

	////////////////////////////////////////
	initial begin
		repeat (20) @(negedge clock);
		resetn = 1'b1;
		repeat (2) @(negedge clock);
		rd_check(rcr_pkg::ADDR_CH23_CODES, 8'h35);
		rd_check(rcr_pkg::ADDR_CH4_CODE, 8'h11);
		rd_check(rcr_pkg::ADDR_SCALING_CFG, 8'h00);
		rd_check(rcr_pkg::ADDR_MODE_DSCG, 8'hF0);
		check("ch4 mv", 13'h1004, mv4);
		check("cfg", cfg_exp(4'h0, 4'hF), {5'h00, cfg});
		for (int c = 0; c < 8; c++) begin
			wr(rcr_pkg::ADDR_CH23_CODES, {1'b1, 3'(c), 1'b1, 3'(c)});
			check("ch2 mv", t2[c], mv2);
			check("ch3 mv", c == 0 ? 13'h0320 : 13'(1100 + 100 * c), mv3);
			check("adjust", {10'h000, 1'b0, c == 0, c == 0}, {10'h000, adj[3:1]});
			rd_check(rcr_pkg::ADDR_CH23_CODES, {1'b1, 3'(c), 1'b1, 3'(c)});
		end
		for (int i = 0; i < 6; i++) begin
			wr(rcr_pkg::ADDR_CH4_CODE, {3'h7, 5'(c4[i])});
			check("ch4 mv", 13'(m4[i]), mv4);
			check("adjust4", {12'h000, i == 0}, {12'h000, adj[3]});
			rd_check(rcr_pkg::ADDR_CH4_CODE, {3'h7, 5'(c4[i])});
		end
		wr(rcr_pkg::ADDR_SCALING_CFG, 8'hDC);
		check("scale en", 13'h0003, {11'h000, en4, en1});
		rd_check(rcr_pkg::ADDR_SCALING_CFG, 8'hDC);
		tick_gap(0, 40);
		tick_gap(1, 20);
		wr(rcr_pkg::ADDR_SCALING_CFG, 8'h67);
		tick_gap(0, 1950);
		tick_gap(1, 3900);
		wr(rcr_pkg::ADDR_SCALING_CFG, 8'h00);
		check("scale off", 13'h0000, {11'h000, en4, en1});
		wr(rcr_pkg::ADDR_MODE_DSCG, 8'hA5);
		check("cfg", cfg_exp(4'h5, 4'hA), {5'h00, cfg});
		mode_pin = 1'b0;
		repeat (2) @(negedge clock);
		check("cfg", cfg_exp(4'hF, 4'hA), {5'h00, cfg});
		pin_clk = 1'b1;
		repeat (2) @(negedge clock);
		check("cfg", cfg_exp(4'h5, 4'hA), {5'h00, cfg});
		// A second reset with other fuse levels must reload every fuse-driven field.
		f2 = 3'h2;
		f3 = 3'h6;
		f4 = 5'h00;
		fd = 1'b0;
		resetn = 1'b0;
		repeat (3) @(negedge clock);
		resetn = 1'b1;
		repeat (2) @(negedge clock);
		rd_check(rcr_pkg::ADDR_CH23_CODES, 8'h62);
		rd_check(rcr_pkg::ADDR_CH4_CODE, 8'h00);
		rd_check(rcr_pkg::ADDR_SCALING_CFG, 8'h00);
		rd_check(rcr_pkg::ADDR_MODE_DSCG, 8'h00);
		check("ch2 mv", t2[2], mv2);
		check("ch3 mv", 13'h06A4, mv3);
		check("ch4 mv", 13'h0320, mv4);
		check("adjust", 13'h0008, {9'h000, adj});
		check("cfg", cfg_exp(4'h0, 4'h0), {5'h00, cfg});
		wr(8'h07, 8'hFF);
		rd_check(8'h07, 8'h00);
		complete_run();
	end
endmodule
